// ===== design/dpx_consts.vh
`ifndef DPX_CONSTS_VH
`define DPX_CONSTS_VH

// ----------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------
`define DPX_PM_AW 24
`define DPX_DM_AW 32
`define DPX_PM_DW 48
`define DPX_DM_DW 40
`define DPX_LO_W 16
`define DPX_HI_W 32
`define DPX_IDX_W 16

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
`define DPX_BLK_BIT 16
`define DPX_INT_MSB 31
`define DPX_INT_LSB 19
`define DPX_TGT_B0 2'h0
`define DPX_TGT_B1 2'h1
`define DPX_TGT_EXT 2'h2

// ----------------------------------------------------------------
// Exchange part select and reset values
// ----------------------------------------------------------------
`define DPX_PART_LO 2'h1
`define DPX_PART_HI 2'h2
`define DPX_PART_FULL 2'h3
`define DPX_PART_HI_BIT 1
`define DPX_LO_RST 16'h0000
`define DPX_HI_RST 32'h0000_0000

// ----------------------------------------------------------------
// Instruction cache geometry
// ----------------------------------------------------------------
`define DPX_IC_ENT 32
`define DPX_IC_IW 5
`define DPX_IC_TW 19

`endif

// ===== design/dpx_exchange.v
`timescale 1ns/1ns
`include "dpx_consts.vh"

module dpx_exchange (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    input wire ce,
    // Load control
    input wire ld_pm,
    input wire ld_dm,
    input wire [1:0] part,
    input wire ext,
    // Source buses
    input wire [`DPX_PM_DW-1:0] pm_in,
    input wire [`DPX_DM_DW-1:0] dm_in,
    input wire [`DPX_PM_DW-1:0] ext_in,
    // Aligned views
    output reg [`DPX_PM_DW-1:0] pm_out,
    output reg [`DPX_DM_DW-1:0] dm_out,
    output wire [`DPX_PM_DW-1:0] px
);

reg [`DPX_LO_W-1:0] exchange_low_part;
reg [`DPX_HI_W-1:0] exchange_high_part;
wire full = (part == `DPX_PART_FULL);

// Combined view, high part on top
assign px = {exchange_high_part, exchange_low_part};

// ----------------------------------------------------------------
// Loads from program bus, data bus or external word
// ----------------------------------------------------------------
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        exchange_low_part <= `DPX_LO_RST;
        exchange_high_part <= `DPX_HI_RST;
    end else if (ce && ld_pm) begin
        if (part[`DPX_PART_HI_BIT])
            exchange_high_part <= pm_in[47:16];
        if (part == `DPX_PART_LO)
            exchange_low_part <= pm_in[31:16];
        if (full)
            exchange_low_part <= pm_in[15:0];
    end else if (ce && ld_dm) begin
        if (full && ext) begin
            exchange_high_part <= ext_in[47:16];
            exchange_low_part <= ext_in[15:0];
        end else begin
            if (part[`DPX_PART_HI_BIT])
                exchange_high_part <= dm_in[39:8];
            if (part == `DPX_PART_LO)
                exchange_low_part <= dm_in[23:8];
            if (full)
                exchange_low_part <= {dm_in[7:0], 8'h00};
        end
    end
end

// ----------------------------------------------------------------
// Zero-filled drive onto both buses
// ----------------------------------------------------------------
always @* begin
    case (part)
        `DPX_PART_LO: begin
            pm_out = {16'h0000, exchange_low_part, 16'h0000};
            dm_out = {16'h0000, exchange_low_part, 8'h00};
        end
        `DPX_PART_HI: begin
            pm_out = {exchange_high_part, 16'h0000};
            dm_out = {exchange_high_part, 8'h00};
        end
        `DPX_PART_FULL: begin
            pm_out = px;
            dm_out = px[47:8];
        end
        default: begin
            pm_out = 48'h0000_0000_0000;
            dm_out = 40'h00_0000_0000;
        end
    endcase
end

endmodule // dpx_exchange

// ===== design/dpx_icache.v
`timescale 1ns/1ns
`include "dpx_consts.vh"

module dpx_icache (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    input wire ce,
    // Lookup
    input wire [`DPX_PM_AW-1:0] lk_addr,
    input wire rd_en,
    output wire hit,
    output reg [`DPX_PM_DW-1:0] rd_data,
    // Fill
    input wire fill_en,
    input wire [`DPX_PM_AW-1:0] fill_addr,
    input wire [`DPX_PM_DW-1:0] fill_data
);

wire [`DPX_IC_ENT-1:0] vld_w;
wire [`DPX_IC_TW-1:0] tag_w [0:`DPX_IC_ENT-1];
wire [`DPX_PM_DW-1:0] dat_w [0:`DPX_IC_ENT-1];
wire [`DPX_IC_IW-1:0] lk_idx = lk_addr[`DPX_IC_IW-1:0];
wire [`DPX_IC_IW-1:0] fl_idx = fill_addr[`DPX_IC_IW-1:0];

// ----------------------------------------------------------------
// One entry per index, written only on a fill
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < `DPX_IC_ENT; g = g + 1) begin : g_ent
        localparam [`DPX_IC_IW-1:0] IDX = g;
        reg v;
        reg [`DPX_IC_TW-1:0] t;
        reg [`DPX_PM_DW-1:0] d;
        always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                v <= 1'b0;
                t <= 19'h0_0000;
                d <= 48'h0000_0000_0000;
            end else if (ce && fill_en && fl_idx == IDX) begin
                v <= 1'b1;
                t <= fill_addr[`DPX_PM_AW-1:`DPX_IC_IW];
                d <= fill_data;
            end
        end
        assign vld_w[g] = v;
        assign tag_w[g] = t;
        assign dat_w[g] = d;
    end
endgenerate

// Tag match on the current fetch address
assign hit = vld_w[lk_idx] &&
    (tag_w[lk_idx] == lk_addr[`DPX_PM_AW-1:`DPX_IC_IW]);

// Registered read of the hit entry
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
        rd_data <= 48'h0000_0000_0000;
    else if (ce && rd_en)
        rd_data <= dat_w[lk_idx];
end

endmodule // dpx_icache

// ===== design/dpx_top.v
`timescale 1ns/1ns
`include "dpx_consts.vh"

module dpx_top (
    // Clock, reset and enable
    input wire mclk,
    input wire rstn,
    input wire ce,
    // Instruction fetch
    input wire fetch_req,
    input wire [`DPX_PM_AW-1:0] fetch_addr,
    output wire [`DPX_PM_DW-1:0] instr,
    output wire instr_vld,
    output reg stall,
    // Data-memory bus access
    input wire dm_req,
    input wire dm_we,
    input wire [`DPX_DM_AW-1:0] dm_addr,
    input wire [`DPX_DM_DW-1:0] dm_wdata,
    output wire [`DPX_DM_DW-1:0] dm_rdata,
    output wire dm_rvld,
    // Program-memory bus data access
    input wire pmd_req,
    input wire pmd_we,
    input wire pmd_wide,
    input wire [`DPX_PM_AW-1:0] pmd_addr,
    input wire [`DPX_PM_DW-1:0] pmd_wdata,
    output wire [`DPX_PM_DW-1:0] pmd_rdata,
    output wire pmd_rvld,
    // Address generator load and use
    input wire [1:0] dag_load,
    input wire [1:0] dag_use,
    // Exchange register
    input wire px_ld_pm,
    input wire px_ld_dm,
    input wire [1:0] px_part,
    input wire px_ext,
    input wire [`DPX_PM_DW-1:0] px_pm_in,
    input wire [`DPX_DM_DW-1:0] px_dm_in,
    input wire [`DPX_PM_DW-1:0] px_ext_in,
    input wire px_to_pm,
    input wire px_to_dm,
    output wire [`DPX_PM_DW-1:0] px_pm_out,
    output wire [`DPX_DM_DW-1:0] px_dm_out,
    // I/O processor bus
    input wire iop_req,
    input wire iop_we,
    input wire [`DPX_DM_AW-1:0] iop_addr,
    input wire [`DPX_PM_DW-1:0] iop_wdata,
    output wire [`DPX_PM_DW-1:0] iop_rdata,
    output wire iop_rvld,
    output wire iop_wait,
    // Core port of both blocks
    output wire [1:0] cp_en,
    output wire [1:0] cp_we,
    output wire [2*`DPX_IDX_W-1:0] cp_addr,
    output wire [2*`DPX_PM_DW-1:0] cp_wdata,
    input wire [2*`DPX_PM_DW-1:0] cp_rdata,
    // I/O port of both blocks
    output wire [1:0] io_en,
    output wire io_we,
    output wire [`DPX_IDX_W-1:0] io_addr,
    output wire [`DPX_PM_DW-1:0] io_wdata,
    input wire [2*`DPX_PM_DW-1:0] io_rdata,
    // External port
    output wire [`DPX_DM_AW-1:0] ext_addr,
    output wire ext_rd,
    output wire ext_wr,
    input wire [`DPX_PM_DW-1:0] ext_data_i,
    output wire [`DPX_PM_DW-1:0] ext_data_o,
    output wire ext_data_oe_n
);

localparam [1:0] ST_RUN = 2'h0;
localparam [1:0] ST_DEF_PM = 2'h1;
localparam [1:0] ST_DEF_FETCH = 2'h2;

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------

// Block or external target of an address
function [1:0] tgt_of;
    input [`DPX_DM_AW-1:0] a;
    begin
        if (|a[`DPX_INT_MSB:`DPX_INT_LSB])
            tgt_of = `DPX_TGT_EXT;
        else if (a[`DPX_BLK_BIT])
            tgt_of = `DPX_TGT_B1;
        else
            tgt_of = `DPX_TGT_B0;
    end
endfunction

// Read data of the addressed target
function [`DPX_PM_DW-1:0] pick;
    input [1:0] s;
    input [2*`DPX_PM_DW-1:0] r;
    input [`DPX_PM_DW-1:0] e;
    begin
        case (s)
            `DPX_TGT_B0: pick = r[47:0];
            `DPX_TGT_B1: pick = r[95:48];
            default: pick = e;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// Reset release
// ----------------------------------------------------------------
reg [1:0] rsync;
wire rst_n = rsync[1];

// Two-stage release of the asynchronous reset
always @(posedge mclk or negedge rstn) begin
    if (!rstn)
        rsync <= 2'b00;
    else
        rsync <= {rsync[0], 1'b1};
end

// ----------------------------------------------------------------
// Control state and declarations
// ----------------------------------------------------------------
reg [1:0] state;
reg [1:0] next_state;
reg def_fetch;
reg def_pend;
reg [`DPX_PM_AW-1:0] def_addr;
reg def_we;
reg [`DPX_PM_DW-1:0] def_wd;
reg [`DPX_PM_AW-1:0] fq_addr;
reg [1:0] last_load;
reg dm_rd_q;
reg [1:0] dm_src_q;
reg pm_rd_q;
reg [1:0] pm_src_q;
reg fet_q;
reg ic_q;
reg fill_q;
reg io_rd_q;
reg [1:0] io_src_q;
reg hz;
reg pm_conf;
reg blk_conf;
reg dm_go;
reg pm_go;
reg pm_fet;
reg pm_w;
reg ic_use;
reg [`DPX_PM_AW-1:0] pm_a;
reg [`DPX_PM_DW-1:0] pm_wd;
wire ic_hit;
wire [`DPX_PM_DW-1:0] ic_data;
wire [`DPX_PM_DW-1:0] xr_px;

// Targets of every requester
wire [1:0] dm_tgt = tgt_of(dm_addr);
wire [1:0] pmd_tgt = tgt_of({8'h00, pmd_addr});
wire [1:0] fet_tgt = tgt_of({8'h00, fetch_addr});
wire [1:0] io_tgt = tgt_of(iop_addr);
wire [1:0] pm_tgt = tgt_of({8'h00, pm_a});
wire [1:0] op_tgt = pmd_req ? pmd_tgt : fet_tgt;

// ----------------------------------------------------------------
// Write data alignment
// ----------------------------------------------------------------
wire [`DPX_PM_DW-1:0] pmd_wd = px_to_pm ? px_pm_out :
    (pmd_wide ? pmd_wdata : {pmd_wdata[47:16], 16'h0000});
wire [`DPX_DM_DW-1:0] dm_wd = px_to_dm ? px_dm_out : dm_wdata;
wire [`DPX_PM_DW-1:0] dm_mem_wd = {dm_wd, 8'h00};
wire px_full_ext = px_to_dm && px_ext && (px_part == `DPX_PART_FULL);
wire [`DPX_PM_DW-1:0] dm_ext_wd = px_full_ext ? xr_px : dm_mem_wd;

// ----------------------------------------------------------------
// Exchange register and instruction cache
// ----------------------------------------------------------------
dpx_exchange u_xr (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .ld_pm(px_ld_pm),
    .ld_dm(px_ld_dm),
    .part(px_part),
    .ext(px_ext),
    .pm_in(px_pm_in),
    .dm_in(px_dm_in),
    .ext_in(px_ext_in),
    .pm_out(px_pm_out),
    .dm_out(px_dm_out),
    .px(xr_px)
);

wire [`DPX_PM_DW-1:0] pm_rw = pick(pm_src_q, cp_rdata, ext_data_i);

dpx_icache u_ic (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .lk_addr(fetch_addr),
    .rd_en(ce & ic_use),
    .hit(ic_hit),
    .rd_data(ic_data),
    .fill_en(ce & fill_q),
    .fill_addr(fq_addr),
    .fill_data(pm_rw)
);

// ----------------------------------------------------------------
// Conflict resolution and issue
// ----------------------------------------------------------------
always @* begin
    hz = |(last_load & dag_use);
    pm_conf = fetch_req & pmd_req & ~ic_hit;
    blk_conf = dm_req & (pmd_req | fetch_req) &
        (dm_tgt == op_tgt);
    dm_go = 1'b0;
    pm_go = 1'b0;
    pm_fet = 1'b0;
    pm_w = 1'b0;
    ic_use = 1'b0;
    pm_a = pmd_addr;
    pm_wd = pmd_wd;
    stall = 1'b0;
    next_state = state;
    case (state)
        ST_RUN: begin
            if (hz) begin
                stall = 1'b1;
            end else begin
                dm_go = dm_req;
                pm_go = (pmd_req | fetch_req) & ~blk_conf;
                pm_fet = ~pmd_req;
                pm_a = pmd_req ? pmd_addr : fetch_addr;
                pm_w = pmd_req & pmd_we;
                ic_use = fetch_req & pmd_req & ic_hit;
                stall = blk_conf | pm_conf;
                if (blk_conf)
                    next_state = ST_DEF_PM;
                else if (pm_conf)
                    next_state = ST_DEF_FETCH;
            end
        end
        ST_DEF_PM: begin
            pm_go = 1'b1;
            pm_fet = def_fetch;
            pm_a = def_addr;
            pm_w = def_we;
            pm_wd = def_wd;
            stall = def_pend;
            next_state = def_pend ? ST_DEF_FETCH : ST_RUN;
        end
        ST_DEF_FETCH: begin
            pm_go = 1'b1;
            pm_fet = 1'b1;
            pm_a = fq_addr;
            next_state = ST_RUN;
        end
        default: begin
            next_state = ST_RUN;
        end
    endcase
end

// Issue strobes frozen by the clock enable
wire dm_issue = ce & dm_go;
wire pm_issue = ce & pm_go;
wire ext_dm = dm_issue & (dm_tgt == `DPX_TGT_EXT);
wire ext_pm = pm_issue & (pm_tgt == `DPX_TGT_EXT);
wire io_conf = (io_tgt == `DPX_TGT_EXT) & (ext_dm | ext_pm);
wire io_issue = ce & iop_req & ~io_conf;
wire ext_io = io_issue & (io_tgt == `DPX_TGT_EXT);

// ----------------------------------------------------------------
// Sequencing, deferred access and read tracking
// ----------------------------------------------------------------
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_RUN;
        def_fetch <= 1'b0;
        def_pend <= 1'b0;
        def_addr <= 24'h00_0000;
        def_we <= 1'b0;
        def_wd <= 48'h0000_0000_0000;
        fq_addr <= 24'h00_0000;
        last_load <= 2'h0;
        dm_rd_q <= 1'b0;
        dm_src_q <= `DPX_TGT_B0;
        pm_rd_q <= 1'b0;
        pm_src_q <= `DPX_TGT_B0;
        fet_q <= 1'b0;
        ic_q <= 1'b0;
        fill_q <= 1'b0;
        io_rd_q <= 1'b0;
        io_src_q <= `DPX_TGT_B0;
    end else if (ce) begin
        state <= next_state;
        // Capture the access that must wait
        if (state == ST_RUN && !hz && (blk_conf | pm_conf)) begin
            def_fetch <= ~pmd_req;
            def_pend <= blk_conf & pm_conf;
            def_addr <= pmd_req ? pmd_addr : fetch_addr;
            def_we <= pmd_req & pmd_we;
            def_wd <= pmd_wd;
            fq_addr <= fetch_addr;
        end
        // One generator load remembered per instruction
        if (hz)
            last_load <= 2'h0;
        else if (!stall)
            last_load <= dag_load;
        dm_rd_q <= dm_go & ~dm_we;
        dm_src_q <= dm_tgt;
        pm_rd_q <= pm_go & ~pm_w & ~pm_fet;
        pm_src_q <= pm_tgt;
        fet_q <= pm_go & pm_fet;
        ic_q <= ic_use;
        fill_q <= pm_go & (state == ST_DEF_FETCH);
        io_rd_q <= iop_req & ~io_conf & ~iop_we;
        io_src_q <= io_tgt;
    end
end

// ----------------------------------------------------------------
// Per-block core and I/O ports
// ----------------------------------------------------------------
genvar b;
generate
    for (b = 0; b < 2; b = b + 1) begin : g_blk
        localparam [1:0] BT = b;
        wire dm_here = dm_issue & (dm_tgt == BT);
        wire pm_here = pm_issue & (pm_tgt == BT);
        // Data-memory bus wins the shared core port
        assign cp_en[b] = dm_here | pm_here;
        assign cp_we[b] = dm_here ? dm_we : (pm_here & pm_w);
        assign cp_addr[b*16 +: 16] = dm_here ?
            dm_addr[15:0] : pm_a[15:0];
        assign cp_wdata[b*48 +: 48] = dm_here ? dm_mem_wd : pm_wd;
        // Independent second port, never stalled by the core
        assign io_en[b] = io_issue & (io_tgt == BT);
    end
endgenerate

assign io_we = iop_we;
assign io_addr = iop_addr[15:0];
assign io_wdata = iop_wdata;

// ----------------------------------------------------------------
// External port, one shared address and data bus
// ----------------------------------------------------------------
assign ext_addr = ext_dm ? dm_addr :
    (ext_pm ? {8'h00, pm_a} : iop_addr);
assign ext_rd = (ext_dm & ~dm_we) | (ext_pm & ~pm_w) |
    (ext_io & ~iop_we);
assign ext_wr = (ext_dm & dm_we) | (ext_pm & pm_w) |
    (ext_io & iop_we);
assign ext_data_o = ext_dm ? dm_ext_wd :
    (ext_pm ? pm_wd : iop_wdata);
assign ext_data_oe_n = ~ext_wr;
assign iop_wait = iop_req & io_conf;

// ----------------------------------------------------------------
// Read returns
// ----------------------------------------------------------------
wire [`DPX_PM_DW-1:0] dm_rw = pick(dm_src_q, cp_rdata, ext_data_i);

assign dm_rdata = dm_rw[47:8];
assign dm_rvld = dm_rd_q;
assign pmd_rdata = pm_rw;
assign pmd_rvld = pm_rd_q;
assign instr = ic_q ? ic_data : pm_rw;
assign instr_vld = ic_q | fet_q;
assign iop_rdata = pick(io_src_q, io_rdata, ext_data_i);
assign iop_rvld = io_rd_q;

endmodule // dpx_top

// ===== testbench/dpx_asserts.sv
`timescale 1ns/1ns
module dpx_asserts (
    // Clock and reset
    input wire mclk, rstn, ce,
    // Core side
    input wire dm_req, dm_we, pmd_req, pmd_we, stall, dm_rvld, pmd_rvld,
    input wire fetch_req,
    input wire [31:0] dm_addr,
    input wire [23:0] pmd_addr,
    input wire [1:0] dag_load, dag_use,
    // Exchange register
    input wire px_ld_pm, px_ld_dm,
    input wire [1:0] px_part,
    input wire [47:0] px_pm_in, px_pm_out,
    input wire [39:0] px_dm_in, px_dm_out,
    // I/O bus
    input wire iop_req, iop_we, iop_wait, iop_rvld,
    input wire [31:0] iop_addr,
    input wire [1:0] io_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Both core buses on one internal block
    wire clash = dm_req && pmd_req && dm_addr[31:19] == 13'h0000 &&
        pmd_addr[23:19] == 5'h00 && dm_addr[16] == pmd_addr[16];

    AST_CLASH_STALL: assert property (
        ce && clash && dag_use == 2'h0 && !$past(stall) |-> stall)
        else $error("core clash without stall");
    AST_CLASH_ORDER: assert property (
        ce && clash && !dm_we && !pmd_we && dag_use == 2'h0 &&
        !$past(stall) |=> dm_rvld && !pmd_rvld ##1 pmd_rvld)
        else $error("clash order wrong");
    AST_IO_ISSUE: assert property (
        ce && iop_req && !iop_wait && !iop_we &&
        iop_addr[31:19] == 13'h0000 |-> io_en[iop_addr[16]] ##1 iop_rvld)
        else $error("io access not served");
    AST_IO_NOSTALL: assert property (
        ce && iop_req && !pmd_req && !(dm_req && fetch_req) &&
        dag_use == 2'h0 |-> !stall)
        else $error("io access stalled core");
    AST_DAG_STALL: assert property (
        ce && !stall && dag_load != 2'h0 |=>
        (dag_use & $past(dag_load)) == 2'h0 || stall)
        else $error("generator reuse without stall");
    AST_PX_HI: assert property (
        ce && px_ld_dm && !px_ld_pm && px_part == 2'h2 |=>
        px_part != 2'h2 || (px_dm_out ^ $past(px_dm_in)) >> 8 == 40'h0 &&
        px_dm_out[7:0] == 8'h00)
        else $error("high part data view wrong");
    AST_PX_LO: assert property (
        px_part == 2'h1 |-> px_pm_out[15:0] == 16'h0000 &&
        px_pm_out[47:32] == 16'h0000 && px_dm_out[7:0] == 8'h00 &&
        px_dm_out[39:24] == 16'h0000)
        else $error("low part fill wrong");
    AST_PX_FULL: assert property (
        ce && px_ld_pm && px_part == 2'h3 |=>
        px_part != 2'h3 || px_pm_out == $past(px_pm_in))
        else $error("full program view wrong");
endmodule // dpx_asserts

bind dpx_top dpx_asserts u_chk (.*);

// ===== testbench/dpx_mem_model.sv
`timescale 1ns/1ns
module dpx_mem_model (
    // Clock
    input logic mclk,
    // Block ports and external port
    input logic [1:0] cp_en, cp_we, io_en,
    input logic [31:0] cp_addr, ext_addr,
    input logic [15:0] io_addr,
    input logic [95:0] cp_wdata,
    input logic ext_rd,
    output logic [95:0] cp_rdata, io_rdata,
    output logic [47:0] ext_data_i
);
    logic [47:0] mem [int];
    int k;

    // Seed word of an unwritten location
    function automatic logic [47:0] pat(int a);
        return {16'hA5C3 ^ a[15:0], a};
    endfunction

    // One-cycle reads per port; idle lines toggle
    always @(posedge mclk) begin
        cp_rdata <= ~cp_rdata;
        io_rdata <= ~io_rdata;
        ext_data_i <= ext_rd ? pat(ext_addr) : ~ext_data_i;
        for (int b = 0; b < 2; b++) begin
            k = b * 65536 + cp_addr[16*b+:16];
            if (cp_en[b] && cp_we[b]) mem[k] = cp_wdata[48*b+:48];
            else if (cp_en[b])
                cp_rdata[48*b+:48] <= mem.exists(k) ? mem[k] : pat(k);
            k = b * 65536 + io_addr;
            if (io_en[b])
                io_rdata[48*b+:48] <= mem.exists(k) ? mem[k] : pat(k);
        end
    end
endmodule // dpx_mem_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
`define CHK(g, x) begin \
    samples_checked++; \
    if ((g) !== (x)) begin \
        miscompares++; \
        $display("[FAIL] %0t got %h exp %h", $time, g, x); \
    end \
end
module tb_top;
    logic mclk = 0, rstn = 0, ce = 1, fetch_req = 0, dm_req = 0, dm_we = 0;
    logic pmd_req = 0, pmd_we = 0, pmd_wide = 1, px_ld_pm = 0, px_ld_dm = 0;
    logic px_ext = 0, px_to_pm = 0, px_to_dm = 0, iop_req = 0, iop_we = 0;
    logic instr_vld, stall, dm_rvld, pmd_rvld, iop_rvld, iop_wait, io_we;
    logic ext_rd, ext_wr, ext_data_oe_n;
    logic [1:0] dag_load = 0, dag_use = 0, px_part = 0, cp_en, cp_we, io_en;
    logic [23:0] fetch_addr = 0, pmd_addr = 0;
    logic [31:0] dm_addr = 0, iop_addr = 0, ext_addr, cp_addr, hi = 0;
    logic [39:0] dm_wdata = 0, px_dm_in = 0, dm_rdata, px_dm_out;
    logic [47:0] pmd_wdata = 0, px_pm_in = 0, px_ext_in = 0, iop_wdata = 0;
    logic [47:0] instr, pmd_rdata, px_pm_out, iop_rdata, io_wdata, e;
    logic [47:0] ext_data_i, ext_data_o, tm [int], q_dm [$], q_pm [$];
    logic [47:0] q_in [$], q_io [$];
    logic [15:0] io_addr, lo = 0;
    logic [95:0] cp_wdata, cp_rdata, io_rdata;
    logic [63:0] r;
    int miscompares = 0, samples_checked = 0;

    dpx_top i_dut (.*);
    dpx_mem_model i_mem (.*);

    // Clock
    always #4 mclk = ~mclk;

    // Reference memory: written words, else seed words
    function automatic int key(logic [31:0] a);
        return a[31:19] != 0 ? int'(a) : a[16] * 65536 + a[15:0];
    endfunction
    function automatic logic [47:0] ref48(logic [31:0] a);
        logic [47:0] s;
        logic [31:0] k;
        k = key(a);
        s = {16'hA5C3 ^ k[15:0], k};
        return tm.exists(key(a)) ? tm[key(a)] : s;
    endfunction

    // Request builders
    task automatic dm(logic w, logic [31:0] a, logic [39:0] d);
        e = ref48(a);
        dm_req <= 1;
        dm_we <= w;
        dm_addr <= a;
        dm_wdata <= d;
        if (w) tm[key(a)] = {d, 8'h00};
        else q_dm.push_back({8'h00, e[47:8]});
    endtask
    task automatic pm(logic w, logic wd, logic [23:0] a, logic [47:0] d);
        pmd_req <= 1;
        pmd_we <= w;
        pmd_wide <= wd;
        pmd_addr <= a;
        pmd_wdata <= d;
        if (w) tm[key(a)] = wd ? d : {d[47:16], 16'h0000};
        else q_pm.push_back(ref48(a));
    endtask
    task automatic fe(logic [23:0] a);
        fetch_req <= 1;
        fetch_addr <= a;
        q_in.push_back(ref48(a));
    endtask

    // Hold requests until a stall-free edge, count stalls
    task automatic go(int ns);
        int n = 0;
        @(negedge mclk);
        while (stall !== 1'b0 && n < 9) begin
            n++;
            @(negedge mclk);
        end
        `CHK(n, ns)
        @(posedge mclk);
        {fetch_req, dm_req, pmd_req, iop_req} <= 4'h0;
        @(posedge mclk);
    endtask

    // Exchange load and aligned views
    task automatic px(int s, logic [1:0] p);
        r = {$urandom, $urandom};
        @(posedge mclk);
        px_part <= p;
        px_ld_pm <= s == 0;
        px_ld_dm <= s != 0;
        px_ext <= s == 2;
        px_pm_in <= r[47:0];
        px_dm_in <= r[39:0];
        px_ext_in <= r[47:0];
        if (s == 1) begin
            if (p[1]) hi = r[39:8];
            if (p == 1) lo = r[23:8];
            if (p == 3) lo = {r[7:0], 8'h00};
        end else begin
            if (p[1]) hi = r[47:16];
            if (p == 1) lo = r[31:16];
            if (p == 3) lo = r[15:0];
        end
        @(posedge mclk);
        {px_ld_pm, px_ld_dm} <= 2'h0;
        @(negedge mclk);
        e = p == 1 ? {16'h0, lo, 16'h0} : p == 2 ? {hi, 16'h0} : {hi, lo};
        `CHK(px_pm_out, e)
        e = p == 1 ? {24'h0, lo, 8'h0} : p == 2 ? {8'h0, hi, 8'h0} :
            {8'h0, hi, lo[15:8]};
        `CHK(px_dm_out, e[39:0])
    endtask

    // Result monitor against reference queues
    task automatic cq(logic v, logic [47:0] g, ref logic [47:0] q [$]);
        if (v === 1'b1) begin
            e = q.pop_front();
            `CHK(g, e)
        end
    endtask
    always @(negedge mclk) begin
        cq(dm_rvld, {8'h00, dm_rdata}, q_dm);
        cq(pmd_rvld, pmd_rdata, q_pm);
        cq(instr_vld, instr, q_in);
        cq(iop_rvld, iop_rdata, q_io);
    end

    // Verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog
    initial begin
        #40000;
        miscompares++;
        end_sim();
    end

    // Main sequence
    initial begin
        void'($urandom(32'hE0AFFBA8));
        repeat (3) @(posedge mclk);
        rstn <= 1;
        repeat (3) @(posedge mclk);
        dm(0, 32'h0002_0001, 0);
        pm(0, 1, 24'h02_0002, 0);
        go(1);
        dm(0, 32'h0002_0003, 0);
        pm(0, 1, 24'h03_0004, 0);
        go(0);
        // Clash held through a frozen cycle: nothing may issue
        dm(0, 32'h0002_0011, 0);
        pm(0, 1, 24'h02_0012, 0);
        ce <= 0;
        fork
            go(2);
            @(posedge mclk) ce <= 1;
        join
        dm(0, 32'h0003_0005, 0);
        iop_req <= 1;
        iop_addr <= 32'h0003_0006;
        q_io.push_back(ref48(32'h0003_0006));
        go(0);
        r = {$urandom, $urandom};
        dm(1, 32'h0003_0007, r[39:0]);
        go(0);
        dm(0, 32'h0003_0007, 0);
        go(0);
        pm(1, 0, 24'h02_0009, r[47:0]);
        go(0);
        pm(0, 1, 24'h02_0009, 0);
        go(0);
        for (int i = 0; i < 4; i++) begin
            fe(i < 2 ? 24'h02_0100 : 24'h02_0101);
            if (i != 2) pm(0, 1, 24'h03_0003, 0);
            go(i == 1 || i == 2 ? 0 : 1);
        end
        for (int j = 1; j < 3; j++) begin
            dag_load <= j;
            @(posedge mclk);
            dag_load <= 0;
            dag_use <= 1;
            dm(0, 32'h0002_0010, 0);
            go(j == 1 ? 1 : 0);
            dag_use <= 0;
        end
        dm(0, 32'h0040_0010, 0);
        go(0);
        for (int s = 0; s < 3; s++)
            for (int p = 1; p < 4; p++)
                if (s < 2 || p == 3) px(s, p);
        // Full external store from the exchange, I/O held off
        @(posedge mclk);
        px_to_dm <= 1;
        iop_req <= 1;
        iop_addr <= 32'h0040_0030;
        dm(1, 32'h0040_0020, 0);
        @(negedge mclk);
        `CHK({ext_wr, ext_data_oe_n, iop_wait}, 3'h5)
        `CHK(ext_data_o, {hi, lo})
        @(posedge mclk);
        {dm_req, iop_req, px_to_dm} <= 3'h0;
        repeat (3) @(posedge mclk);
        `CHK(q_dm.size() + q_pm.size() + q_in.size() + q_io.size(), 0)
        end_sim();
    end
endmodule // tb_top
